// ---- verilog/csi_regs.svh ----
// Register indices, field positions and reset values of the interrupt unit.
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH

// Register indices; the byte address is four times the index.
`define CSI_IDX_CHG_FLAGS   8'h04
`define CSI_IDX_CHG_MASK    8'h05
`define CSI_IDX_GLOB_CTRL   8'h1e
`define CSI_IDX_SOCK_FLAGS  8'h40
`define CSI_IDX_SOCK_MASK   8'h41
`define CSI_IDX_ROUTE       8'h42
`define CSI_IDX_CARD_CTRL   8'h91

// Legacy status-change flag and mask bits.
`define CSI_CHG_BATT_ONE    0
`define CSI_CHG_BATT_TWO    1
`define CSI_CHG_READY       2
`define CSI_CHG_PWR_DONE    3
`define CSI_CHG_DETECT      4
`define CSI_CHG_USED        8'h1f

// Socket event flag and mask bits.
`define CSI_SOCK_CARD_STATUS_CHANGE_LINE     0
`define CSI_SOCK_DET_ONE    1
`define CSI_SOCK_DET_TWO    2
`define CSI_SOCK_PWR_DONE   3
`define CSI_SOCK_USED       32'h0000000f

// Global control: flag clear mode bit.
`define CSI_GLOB_CLR_MODE   2

// Card control byte: functional request status bit.
`define CSI_CARD_FUNC       0

// Routing register fields.
`define CSI_RT_CSC_LSB      0
`define CSI_RT_FUNC_LSB     4
`define CSI_RT_TIE          8
`define CSI_RT_SERIAL       9
`define CSI_RT_USED         32'h00000377

// Reset values.
`define CSI_RST_BYTE        8'h00
`define CSI_RST_WORD        32'h00000000

`endif

// ---- verilog/csi_pkg.sv ----
// Types shared by the card socket interrupt unit.
`default_nettype none
package csi_pkg;

  // Kind of card present in the socket.
  typedef enum logic [1:0]
  {
    CARD_NONE  = 2'b00,
    CARD_MEM16 = 2'b01,
    CARD_IO16  = 2'b10,
    CARD_BUS32 = 2'b11
  } csi_card_e;

endpackage
`default_nettype wire

// ---- verilog/csi_irq_unit.sv ----
// Card socket interrupt unit: event capture, flags, masks and routing.
//
// Function
// - Sense socket events, notify host selectably.
// - Each source is status change or functional.
// - Status changes: insertion, removal, signal transitions.
// - 16-bit in legacy set, 32-bit in socket set.
// - Parallel signalling leaves on seven multipurpose terminals; serial IRQ has its own line.
// - Tied bus interrupt on terminal 0 silences parallel and serial IRQ.
// - Battery detects set and mask bits 1, 0.
// - Ready transition sets and masks bit 2.
// - I/O status-change line sets, masks bit 0.
// - 16-bit power-up done sets, masks bit 3.
// - Functional requests unmasked, shown in 91h bit 0.
// - Socket event bits 0..3, gated by socket mask.
// - Functional requests invalid for 16-bit memory cards.
// - Insertion and removal flagged for every card type.
// - Legacy flags clear on read or write-one.
// - Socket event flags clear by writing one.
//
// Register access over APB was chosen for this implementation.
`include "csi_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module csi_irq_unit #(
  parameter int N_TERM = 7
)(
  // Clock and reset.
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Socket side.
  input  wire logic [1:0]  CARD_TYPE,
  input  wire logic [1:0]  CARD_DETECT,
  input  wire logic        BATTERY_DETECT_ONE,
  input  wire logic        BATTERY_DETECT_TWO,
  input  wire logic        CARD_READY,
  input  wire logic        CARD_STATUS_CHANGE_LINE,
  input  wire logic        BUS_CARD_STATUS_CHANGE_LINE,
  input  wire logic        IO_CARD_IRQ_REQUEST,
  input  wire logic        BUS_CARD_IRQ_REQUEST,
  input  wire logic        POWER_UP_DONE,
  // Host side.
  output logic [N_TERM-1:0] MULTIPURPOSE_TERMINALS,
  output logic             SERIALIZED_IRQ_LINE,
  output logic             IRQ
);

  // The routing fields are three bits wide and serve seven terminals.
  generate
    if (N_TERM != 7)
    begin : g_bad_term
      $error("N_TERM must be 7");
    end
  endgenerate

  csi_pkg::csi_card_e card;
  assign card = csi_pkg::csi_card_e'(CARD_TYPE);

  // Previous samples of the socket lines for edge detection.
  logic [1:0] det_q;
  logic       bat1_q;
  logic       bat2_q;
  logic       rdy_q;
  logic       sts_q;
  logic       bsts_q;

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      det_q  <= 2'b00;
      bat1_q <= 1'b0;
      bat2_q <= 1'b0;
      rdy_q  <= 1'b0;
      sts_q  <= 1'b0;
      bsts_q <= 1'b0;
    end
    else
    begin
      det_q  <= CARD_DETECT;
      bat1_q <= BATTERY_DETECT_ONE;
      bat2_q <= BATTERY_DETECT_TWO;
      rdy_q  <= CARD_READY;
      sts_q  <= CARD_STATUS_CHANGE_LINE;
      bsts_q <= BUS_CARD_STATUS_CHANGE_LINE;
    end
  end

  // Event decode by card type; edge events are one-cycle strobes, power done follows its level.
  logic [1:0] det_chg;
  logic       is_mem;
  logic       is_io;
  logic       is_bus;
  logic [7:0] chg_set;
  logic [31:0] sock_set;

  assign det_chg = det_q ^ CARD_DETECT;
  assign is_mem  = (card == csi_pkg::CARD_MEM16);
  assign is_io   = (card == csi_pkg::CARD_IO16);
  assign is_bus  = (card == csi_pkg::CARD_BUS32);

  always_comb
  begin
    chg_set  = 8'h00;
    sock_set = 32'h00000000;
    // Battery detects only mean something on memory cards.
    chg_set[`CSI_CHG_BATT_ONE] = is_mem &
      (bat1_q ^ BATTERY_DETECT_ONE);
    chg_set[`CSI_CHG_BATT_TWO] = is_mem &
      (bat2_q ^ BATTERY_DETECT_TWO);
    chg_set[`CSI_CHG_READY] = is_mem &
      (rdy_q ^ CARD_READY);
    // The I/O line shares bit 0; only its assertion counts.
    if (is_io && CARD_STATUS_CHANGE_LINE && !sts_q)
    begin
      chg_set[`CSI_CHG_BATT_ONE] = 1'b1;
    end
    chg_set[`CSI_CHG_PWR_DONE] = (is_mem | is_io) &
      POWER_UP_DONE;
    chg_set[`CSI_CHG_DETECT] = |det_chg;
    sock_set[`CSI_SOCK_CARD_STATUS_CHANGE_LINE] = is_bus &
      BUS_CARD_STATUS_CHANGE_LINE & !bsts_q;
    sock_set[`CSI_SOCK_DET_ONE] = det_chg[0];
    sock_set[`CSI_SOCK_DET_TWO] = det_chg[1];
    sock_set[`CSI_SOCK_PWR_DONE] = is_bus &
      POWER_UP_DONE;
  end

  // Functional request: valid for I/O and bus cards only, never masked.
  logic func_req;
  assign func_req = (is_io & IO_CARD_IRQ_REQUEST) |
                    (is_bus & BUS_CARD_IRQ_REQUEST);

  // APB decode. Zero wait states; read data is latched in setup.
  logic [9:0] idx;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;

  assign idx   = PADDR[11:2];
  assign setup = PSEL & !PENABLE;
  assign acc   = PSEL & PENABLE;
  assign wr    = acc & PWRITE;
  assign rd    = acc & !PWRITE;

  always_comb
  begin
    unique case (idx)
      {2'b00, `CSI_IDX_CHG_FLAGS},
      {2'b00, `CSI_IDX_CHG_MASK},
      {2'b00, `CSI_IDX_GLOB_CTRL},
      {2'b00, `CSI_IDX_SOCK_FLAGS},
      {2'b00, `CSI_IDX_SOCK_MASK},
      {2'b00, `CSI_IDX_ROUTE},
      {2'b00, `CSI_IDX_CARD_CTRL}: hit = 1'b1;
      default:                    hit = 1'b0;
    endcase
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = acc & !hit;

  // Configuration registers written by software.
  logic [7:0]  chg_mask_q;
  logic [7:0]  glob_q;
  logic [31:0] sock_mask_q;
  logic [31:0] route_q;

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      chg_mask_q  <= `CSI_RST_BYTE;
      glob_q      <= `CSI_RST_BYTE;
      sock_mask_q <= `CSI_RST_WORD;
      route_q     <= `CSI_RST_WORD;
    end
    else if (wr)
    begin
      if (idx == {2'b00, `CSI_IDX_CHG_MASK})
        chg_mask_q <= PWDATA[7:0] & `CSI_CHG_USED;
      if (idx == {2'b00, `CSI_IDX_GLOB_CTRL})
        glob_q <= PWDATA[7:0];
      if (idx == {2'b00, `CSI_IDX_SOCK_MASK})
        sock_mask_q <= PWDATA & `CSI_SOCK_USED;
      if (idx == {2'b00, `CSI_IDX_ROUTE})
        route_q <= PWDATA & `CSI_RT_USED;
    end
  end

  // Legacy flags. Reset value clears, so clear-on-read is the default.
  logic       clr_w1c;
  logic [7:0] chg_flags_q;
  logic [7:0] chg_clr;

  assign clr_w1c = glob_q[`CSI_GLOB_CLR_MODE];

  always_comb
  begin
    chg_clr = 8'h00;
    if (idx == {2'b00, `CSI_IDX_CHG_FLAGS})
    begin
      if (clr_w1c && wr)
        chg_clr = PWDATA[7:0];
      else if (!clr_w1c && rd)
        chg_clr = 8'hff;
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      chg_flags_q <= `CSI_RST_BYTE;
    else
      chg_flags_q <= (chg_flags_q & ~chg_clr) | chg_set;
  end

  // Socket event flags, write one to clear; set wins likewise.
  logic [31:0] sock_flags_q;
  logic [31:0] sock_clr;

  assign sock_clr = (wr && idx == {2'b00, `CSI_IDX_SOCK_FLAGS}) ?
                    PWDATA : 32'h00000000;

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      sock_flags_q <= `CSI_RST_WORD;
    else
      sock_flags_q <= (sock_flags_q & ~sock_clr) | sock_set;
  end

  // Read mux, sampled in the setup cycle so PRDATA is a flop.
  // The clear-on-read side effect acts at the access edge, so the
  // value returned is the one seen before that clear.
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h00000000;
    unique case (idx)
      {2'b00, `CSI_IDX_CHG_FLAGS}:  rdata[7:0] = chg_flags_q;
      {2'b00, `CSI_IDX_CHG_MASK}:   rdata[7:0] = chg_mask_q;
      {2'b00, `CSI_IDX_GLOB_CTRL}:  rdata[7:0] = glob_q;
      {2'b00, `CSI_IDX_SOCK_FLAGS}: rdata = sock_flags_q;
      {2'b00, `CSI_IDX_SOCK_MASK}:  rdata = sock_mask_q;
      {2'b00, `CSI_IDX_ROUTE}:      rdata = route_q;
      {2'b00, `CSI_IDX_CARD_CTRL}:
        rdata[`CSI_CARD_FUNC] = func_req;
      default:                      rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      PRDATA <= `CSI_RST_WORD;
    else if (setup && !PWRITE)
      PRDATA <= rdata;
  end

  // Request levels. Status changes are masked; functional ones are not.
  logic csc_req;
  logic any_req;

  assign csc_req = |(chg_flags_q & chg_mask_q) |
                   |(sock_flags_q & sock_mask_q);
  assign any_req = csc_req | func_req;

  // Terminal routing. With the tie bit set every request goes out on
  // terminal 0 as the bus interrupt; otherwise, outside serial mode, status
  // changes and functional requests use their own terminals, which may share one.
  logic [2:0]        csc_term;
  logic [2:0]        func_term;
  logic              tie;
  logic              serial;
  logic [N_TERM-1:0] term_d;
  logic [N_TERM-1:0] term_q;

  assign csc_term  = route_q[`CSI_RT_CSC_LSB +: 3];
  assign func_term = route_q[`CSI_RT_FUNC_LSB +: 3];
  assign tie       = route_q[`CSI_RT_TIE];
  assign serial    = route_q[`CSI_RT_SERIAL];

  genvar t;
  generate
    for (t = 0; t < N_TERM; t = t + 1)
    begin : g_term
      // In serial mode the IRQ lines go quiet, but terminal 0 may still
      // carry the bus interrupt when tied.
      assign term_d[t] =
        (tie && t == 0 && any_req) ||
        (!tie && !serial && csc_req && csc_term == 3'(t)) ||
        (!tie && !serial && func_req &&
         func_term == 3'(t));
    end
  endgenerate

  // Outputs are registered so the host sees glitch-free levels.
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      term_q              <= '0;
      SERIALIZED_IRQ_LINE <= 1'b0;
      IRQ                 <= 1'b0;
    end
    else
    begin
      term_q              <= term_d;
      SERIALIZED_IRQ_LINE <= serial & !tie & any_req;
      IRQ                 <= any_req;
    end
  end

  assign MULTIPURPOSE_TERMINALS = term_q;

endmodule // csi_irq_unit
`default_nettype wire

// ---- test/csi_card_model.sv ----
// Socket-side model of the card lines seen by the interrupt unit.
`timescale 1ns/1ns
`default_nettype none
module csi_card_model (
  // Clock.
  input  wire logic       MCLK,
  // Bits: battery one, battery two, ready, I/O change, bus change,
  // power done, detect zero, detect one, I/O request, bus request.
  output logic      [9:0] LINE
);
  initial LINE = '0;

  // Lines move only just after an edge, so the unit samples them clean.
  task automatic flip(input int b);
    @(posedge MCLK);
    LINE[b] <= ~LINE[b];
  endtask

  // A change line rises then falls; power done lasts one cycle.
  task automatic pulse(input int b);
    flip(b);
    flip(b);
  endtask
endmodule // csi_card_model
`default_nettype wire

// ---- test/csi_irq_unit_sva.sv ----
// Port checker for the card socket interrupt unit.
`timescale 1ns/1ns
`default_nettype none
`include "csi_regs.svh"
module csi_irq_unit_sva #(
  parameter int N_TERM = 7
)(
  // Clock, reset and bus.
  input wire logic              MCLK,
  input wire logic              RESETN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [11:0]       PADDR,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Socket and host side.
  input wire logic [1:0]        CARD_TYPE,
  input wire logic              IO_CARD_IRQ_REQUEST,
  input wire logic              BUS_CARD_IRQ_REQUEST,
  input wire logic [N_TERM-1:0] MULTIPURPOSE_TERMINALS,
  input wire logic              SERIALIZED_IRQ_LINE,
  input wire logic              IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  // Raised request with no bus traffic and no functional request.
  sequence quiet_s;
    IRQ && !PSEL && !IO_CARD_IRQ_REQUEST && !BUS_CARD_IRQ_REQUEST;
  endsequence

  ready_a: assert property (PREADY) else $error("ready low");
  err_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  rdz_a: assert property (PSLVERR && !PWRITE |-> PRDATA == '0)
    else $error("unmapped read not zero");
  map_a: assert property (PSEL && PENABLE &&
    PADDR[11:2] == {2'b00, `CSI_IDX_CHG_MASK} |-> !PSLVERR)
    else $error("mapped access refused");
  io_func_a: assert property (IO_CARD_IRQ_REQUEST &&
    CARD_TYPE == csi_pkg::CARD_IO16 |=> IRQ) else $error("io request lost");
  bus_func_a: assert property (BUS_CARD_IRQ_REQUEST &&
    CARD_TYPE == csi_pkg::CARD_BUS32 |=> IRQ) else $error("bus request lost");
  term_irq_a: assert property (|MULTIPURPOSE_TERMINALS |-> IRQ)
    else $error("terminal without request");
  serial_quiet_a: assert property (SERIALIZED_IRQ_LINE |->
    MULTIPURPOSE_TERMINALS[N_TERM-1:1] == '0) else $error("irq in serial");
  flag_hold_a: assert property (quiet_s ##1 quiet_s |=> IRQ)
    else $error("request dropped");
endmodule // csi_irq_unit_sva

bind csi_irq_unit csi_irq_unit_sva #(.N_TERM(N_TERM)) u_sva (.MCLK, .RESETN,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .CARD_TYPE,
  .IO_CARD_IRQ_REQUEST, .BUS_CARD_IRQ_REQUEST, .MULTIPURPOSE_TERMINALS,
  .SERIALIZED_IRQ_LINE, .IRQ);
`default_nettype wire

// ---- test/csi_irq_unit_tb.sv ----
// Self-checking bench for the card socket interrupt unit.
`timescale 1ns/1ns
`default_nettype none
`include "csi_regs.svh"
module csi_irq_unit_tb;
  // Bench signals.
  logic        mclk = 0;
  logic        resetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, err, irq, ser;
  logic [1:0]  ctype = csi_pkg::CARD_NONE;
  logic [9:0]  ln;
  logic [6:0]  term;
  int          error_cnt = 0;
  int          check_count = 0;

  csi_card_model sock (.MCLK(mclk), .LINE(ln));
  csi_irq_unit dut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CARD_TYPE(ctype), .CARD_DETECT(ln[7:6]), .BATTERY_DETECT_ONE(ln[0]),
    .BATTERY_DETECT_TWO(ln[1]), .CARD_READY(ln[2]),
    .CARD_STATUS_CHANGE_LINE(ln[3]), .BUS_CARD_STATUS_CHANGE_LINE(ln[4]),
    .IO_CARD_IRQ_REQUEST(ln[8]), .BUS_CARD_IRQ_REQUEST(ln[9]),
    .POWER_UP_DONE(ln[5]), .MULTIPURPOSE_TERMINALS(term),
    .SERIALIZED_IRQ_LINE(ser), .IRQ(irq));

  // Clock of 8 ns.
  initial forever #4 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  // One bus transfer; the wait for ready is bounded.
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      tally_and_finish();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] exp);
    apb(0, i, '0);
    chk(rdat, exp);
  endtask

  // Event to flag is one edge, flag to request one more.
  task automatic see(input logic [31:0] exp);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(32'(irq), exp);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1;
    rd(`CSI_IDX_CHG_FLAGS, 0);
    rd(8'h77, 0);
    chk(32'(err), 1);
    apb(1, `CSI_IDX_CARD_CTRL, 1);
    rd(`CSI_IDX_CARD_CTRL, 0);
    apb(1, `CSI_IDX_SOCK_MASK, '1);
    rd(`CSI_IDX_SOCK_MASK, 32'hf);
    apb(1, `CSI_IDX_SOCK_MASK, 0);
    $display("registers done");
    // Memory card: a masked event stays quiet, a request is ignored.
    ctype <= csi_pkg::CARD_MEM16;
    sock.flip(8);
    sock.flip(0);
    see(0);
    apb(1, `CSI_IDX_CHG_MASK, '1);
    rd(`CSI_IDX_CHG_MASK, 32'h1f);
    rd(`CSI_IDX_CARD_CTRL, 0);
    sock.flip(1);
    sock.flip(2);
    sock.pulse(5);
    sock.flip(7);
    see(1);
    rd(`CSI_IDX_CHG_FLAGS, 32'h1f);
    rd(`CSI_IDX_CHG_FLAGS, 0);
    see(0);
    $display("memory card done");
    // I/O card in write-one-clear mode; request is live, never masked.
    ctype <= csi_pkg::CARD_IO16;
    apb(1, `CSI_IDX_GLOB_CTRL, 32'h4);
    sock.pulse(3);
    rd(`CSI_IDX_CHG_FLAGS, 1);
    rd(`CSI_IDX_CHG_FLAGS, 1);
    apb(1, `CSI_IDX_CHG_FLAGS, 1);
    rd(`CSI_IDX_CHG_FLAGS, 0);
    rd(`CSI_IDX_CARD_CTRL, 1);
    sock.flip(8);
    see(0);
    $display("io card done");
    // Bus card events and write-one-clear socket flags.
    ctype <= csi_pkg::CARD_BUS32;
    apb(1, `CSI_IDX_SOCK_MASK, 32'h8);
    sock.pulse(4);
    sock.pulse(5);
    sock.flip(6);
    see(1);
    rd(`CSI_IDX_SOCK_FLAGS, 32'hf);
    apb(1, `CSI_IDX_SOCK_FLAGS, 32'h6);
    rd(`CSI_IDX_SOCK_FLAGS, 32'h9);
    apb(1, `CSI_IDX_SOCK_FLAGS, 32'h9);
    rd(`CSI_IDX_CHG_FLAGS, 32'h10);
    apb(1, `CSI_IDX_CHG_FLAGS, 32'h10);
    sock.flip(9);
    rd(`CSI_IDX_CARD_CTRL, 1);
    sock.flip(9);
    see(0);
    $display("bus card done");
    // Routing to one terminal, then serial mode.
    apb(1, `CSI_IDX_ROUTE, 32'h72);
    sock.flip(6);
    see(1);
    chk(32'(term), 32'h4);
    apb(1, `CSI_IDX_ROUTE, 32'h272);
    see(1);
    chk({ser, term}, 32'h80);
    $display("routing done");
    tally_and_finish();
  end
endmodule // csi_irq_unit_tb
`default_nettype wire
